/* bmr_params.svh */
`ifndef BMR_PARAMS_SVH
`define BMR_PARAMS_SVH
`define BMR_A_STAT 8'h00
`define BMR_A_BAL1 8'h01
`define BMR_A_BAL2 8'h02
`define BMR_A_BAL3 8'h03
`define BMR_A_CTL1 8'h04
`define BMR_A_CTL2 8'h05
`define BMR_A_TEMP_TWO_RESULT_LOW 8'h2f
`define BMR_A_TEMP_THREE_RESULT_HIGH 8'h30
`define BMR_A_TEMP_THREE_RESULT_LOW 8'h31
`define BMR_A_COULOMB_RESULT_HIGH 8'h32
`define BMR_A_COULOMB_RESULT_LOW 8'h33
`define BMR_A_GAIN1 8'h50
`define BMR_A_OFFS 8'h51
`define BMR_A_GAIN2 8'h59
`define BMR_B_READY 7
`define BMR_B_CHIPF 5
`define BMR_B_ALERT 4
`define BMR_B_UV 3
`define BMR_B_OV 2
`define BMR_B_SCD 1
`define BMR_B_OCD 0
`define BMR_STAT_MASK 8'hbf
`define BMR_BAL_MASK 8'h1f
`define BMR_B_LOAD 7
`define BMR_B_ADC 4
`define BMR_B_TSEL 3
`define BMR_B_RSV2 2
`define BMR_B_SHA 1
`define BMR_B_SHB 0
`define BMR_CTL1_MASK 8'h1f
`define BMR_B_DDIS 7
`define BMR_B_CCEN 6
`define BMR_B_ONE 5
`define BMR_B_DSG 1
`define BMR_B_CHG 0
`define BMR_CC_MS 250
`define BMR_CLK_HZ 10000000
`define BMR_CC_CYC ((`BMR_CC_MS * (`BMR_CLK_HZ / 1000)))
`define BMR_TS_HI_MASK 8'h3f
`endif

/* bmr_pkg.sv */
package bmr_pkg;
    typedef enum logic [1:0]
    {
        SH_IDLE = 2'b00,
        SH_ARMED = 2'b01,
        SH_DONE = 2'b10
    } bmr_shut_t;

    typedef enum logic [1:0]
    {
        CC_OFF = 2'b00,
        CC_SINGLE = 2'b01,
        CC_CONT = 2'b10
    } bmr_cc_t;
endpackage : bmr_pkg

/* bmr_snap_mem.sv */
`timescale 1ns/1ps
// Holds the two temperature words shown to the host; read data registered.
module bmr_snap_mem
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic we_i,
    input wire logic [1:0] waddr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [1:0] raddr_i,
    output logic [15:0] rdata_o
);
    logic [15:0] mem_r [0:3];
    logic [15:0] rdata_r;

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_r[waddr_i] <= wdata_i;
        end
        if (!resetn_i)
        begin
            rdata_r <= 16'h0000;
        end
        else
        begin
            rdata_r <= mem_r[raddr_i];
        end
    end

    assign rdata_o = rdata_r;
endmodule : bmr_snap_mem

/* bmr_regs.sv */
`timescale 1ns/1ps
`include "bmr_params.svh"
module bmr_regs
#(
    parameter int unsigned CC_CYCLES = `BMR_CC_CYC,
    parameter logic [7:0] GAIN1_VAL = 8'h00,
    parameter logic [7:0] OFFS_VAL = 8'h00,
    parameter logic [7:0] GAIN2_VAL = 8'h00
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic txn_start_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    input wire logic chip_fault_i,
    input wire logic alert_in_i,
    input wire logic alert_drive_i,
    input wire logic uv_i,
    input wire logic ov_raw_i,
    input wire logic scd_i,
    input wire logic ocd_i,
    input wire logic load_seen_i,
    input wire logic [15:0] cc_sample_i,
    input wire logic ts_valid_i,
    input wire logic [13:0] ts2_i,
    input wire logic [13:0] ts3_i,
    output logic [14:0] cell_balance_enable_o,
    output logic adc_enable_o,
    output logic ov_protect_enable_o,
    output logic temp_source_therm_o,
    output logic shutdown_o,
    output logic protection_delay_bypass_o,
    output logic cc_active_o,
    output logic discharge_driver_pin_o,
    output logic charge_driver_pin_o
);
    typedef struct packed
    {
        logic [7:0] stat;
        logic [14:0] bal;
        logic adc;
        logic tsel;
        logic rsv2;
        logic sha;
        logic shb;
        logic [7:0] ctl2;
        bmr_pkg::bmr_shut_t shut;
        logic shutdown;
        bmr_pkg::bmr_cc_t cc;
        logic cc_on;
        logic [31:0] cnt;
        logic load;
        logic [7:0] rdata;
        logic [15:0] cc_lat;
        logic [7:0] lo_hold;
        logic lo_valid;
        logic snap_we;
        logic [1:0] snap_wa;
        logic [15:0] snap_wd;
    } bmr_state_t;

    bmr_state_t st_r;
    bmr_state_t st_nxt;
    logic [15:0] snap_rd;
    logic [1:0] snap_ra;

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
        is_addr = (a == b);
    endfunction : is_addr

    // Word slot for the high/low pair at an address
    function automatic logic [1:0] slot(input logic [7:0] a);
        if (is_addr(a, `BMR_A_TEMP_THREE_RESULT_HIGH) || is_addr(a, `BMR_A_TEMP_THREE_RESULT_LOW))
            slot = 2'h1;
        else if (is_addr(a, `BMR_A_COULOMB_RESULT_HIGH) || is_addr(a, `BMR_A_COULOMB_RESULT_LOW))
            slot = 2'h2;
        else
            slot = 2'h0;
    endfunction : slot

    assign snap_ra = slot(addr_i);

    bmr_snap_mem u_snap
    (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .we_i(st_r.snap_we),
        .waddr_i(st_r.snap_wa),
        .wdata_i(st_r.snap_wd),
        .raddr_i(snap_ra),
        .rdata_o(snap_rd)
    );

    always_comb
    begin
        logic [7:0] ev;
        logic [7:0] clr;
        logic done;
        logic [15:0] word;
        st_nxt = st_r;
        ev = 8'h00;
        clr = 8'h00;
        done = 1'b0;
        word = 16'h0000;
        st_nxt.snap_we = 1'b0;
        // Write slot is kept so temperature words alternate
        st_nxt.snap_wd = 16'h0000;
        ev[`BMR_B_CHIPF] = chip_fault_i;
        ev[`BMR_B_ALERT] = alert_in_i && !alert_drive_i;
        // fault latches; OV needs converter on
        ev[`BMR_B_UV] = uv_i;
        ev[`BMR_B_OV] = ov_raw_i && st_r.adc;
        ev[`BMR_B_SCD] = scd_i;
        ev[`BMR_B_OCD] = ocd_i;
        case (st_r.cc)
            bmr_pkg::CC_OFF:
            begin
                st_nxt.cnt = 32'h0;
                if (st_r.ctl2[`BMR_B_CCEN])
                    st_nxt.cc = bmr_pkg::CC_CONT;
                else if (st_r.ctl2[`BMR_B_ONE])
                    st_nxt.cc = bmr_pkg::CC_SINGLE;
            end
            bmr_pkg::CC_SINGLE, bmr_pkg::CC_CONT:
            begin
                st_nxt.cnt = st_r.cnt + 32'h1;
                if (st_r.cnt == CC_CYCLES - 1)
                begin
                    done = 1'b1;
                    st_nxt.cnt = 32'h0;
                    if (!st_r.ctl2[`BMR_B_CCEN])
                        st_nxt.cc = bmr_pkg::CC_OFF;
                end
                else if (st_r.cc == bmr_pkg::CC_CONT &&
                         !st_r.ctl2[`BMR_B_CCEN])
                    st_nxt.cc = bmr_pkg::CC_OFF;
            end
            default:
                st_nxt.cc = bmr_pkg::CC_OFF;
        endcase
        ev[`BMR_B_READY] = done;
        // Coulomb word has its own latch; the store keeps temperatures
        if (done)
        begin
            st_nxt.cc_lat = cc_sample_i;
        end
        if (ts_valid_i && !st_r.snap_we)
        begin
            // source chosen by tsel outside; stored here
            st_nxt.snap_we = 1'b1;
            st_nxt.snap_wa = st_r.snap_wa == 2'h0 ? 2'h1 : 2'h0;
            word = {2'b00, st_r.snap_wa == 2'h0 ? ts3_i : ts2_i};
            st_nxt.snap_wd = word;
        end
        if (wr_i)
        begin
            if (is_addr(addr_i, `BMR_A_STAT))
                clr = wdata_i & `BMR_STAT_MASK;
            if (is_addr(addr_i, `BMR_A_BAL1))
                st_nxt.bal[4:0] = wdata_i[4:0];
            if (is_addr(addr_i, `BMR_A_BAL2))
                st_nxt.bal[9:5] = wdata_i[4:0];
            if (is_addr(addr_i, `BMR_A_BAL3))
                st_nxt.bal[14:10] = wdata_i[4:0];
            if (is_addr(addr_i, `BMR_A_CTL1))
            begin
                st_nxt.adc = wdata_i[`BMR_B_ADC];
                st_nxt.tsel = wdata_i[`BMR_B_TSEL];
                st_nxt.rsv2 = wdata_i[`BMR_B_RSV2];
                st_nxt.sha = wdata_i[`BMR_B_SHA];
                st_nxt.shb = wdata_i[`BMR_B_SHB];
                case (st_r.shut)
                    bmr_pkg::SH_IDLE:
                        st_nxt.shut = (!st_r.sha && !st_r.shb &&
                            wdata_i[1:0] == 2'b01) ? bmr_pkg::SH_ARMED
                            : bmr_pkg::SH_IDLE;
                    bmr_pkg::SH_ARMED:
                        st_nxt.shut = (wdata_i[1:0] == 2'b10) ?
                            bmr_pkg::SH_DONE : bmr_pkg::SH_IDLE;
                    bmr_pkg::SH_DONE:
                        st_nxt.shut = bmr_pkg::SH_DONE;
                    default:
                        st_nxt.shut = bmr_pkg::SH_IDLE;
                endcase
            end
            if (is_addr(addr_i, `BMR_A_CTL2))
                st_nxt.ctl2 = wdata_i;
        end
        st_nxt.stat = ((st_r.stat & ~clr) | ev) & `BMR_STAT_MASK;
        if (done && st_r.cc == bmr_pkg::CC_SINGLE)
            st_nxt.ctl2[`BMR_B_ONE] = 1'b0;
        if (st_r.ctl2[`BMR_B_CCEN])
            st_nxt.ctl2[`BMR_B_ONE] = st_nxt.ctl2[`BMR_B_ONE] & 1'b0;
        st_nxt.shutdown = (st_nxt.shut == bmr_pkg::SH_DONE);
        st_nxt.cc_on = (st_nxt.cc != bmr_pkg::CC_OFF);
        // load detect only with charge off
        st_nxt.load = load_seen_i && !st_r.ctl2[`BMR_B_CHG];
        st_nxt.rdata = 8'h00;
        if (txn_start_i)
            st_nxt.lo_valid = 1'b0;
        if (rd_i)
        begin
            case (addr_i)
                `BMR_A_STAT: st_nxt.rdata = st_r.stat;
                `BMR_A_BAL1: st_nxt.rdata = {3'b000, st_r.bal[4:0]};
                `BMR_A_BAL2: st_nxt.rdata = {3'b000, st_r.bal[9:5]};
                `BMR_A_BAL3: st_nxt.rdata = {3'b000, st_r.bal[14:10]};
                `BMR_A_CTL1: st_nxt.rdata = {st_r.load, 2'b00, st_r.adc,
                    st_r.tsel, st_r.rsv2, st_r.sha, st_r.shb};
                `BMR_A_CTL2: st_nxt.rdata = st_r.ctl2;
                // high read freezes the matching low byte
                `BMR_A_TEMP_THREE_RESULT_HIGH, `BMR_A_COULOMB_RESULT_HIGH:
                begin
                    word = is_addr(addr_i, `BMR_A_COULOMB_RESULT_HIGH) ? st_r.cc_lat
                        : snap_rd;
                    st_nxt.rdata = is_addr(addr_i, `BMR_A_COULOMB_RESULT_HIGH) ?
                        word[15:8] : word[15:8] & `BMR_TS_HI_MASK;
                    st_nxt.lo_hold = word[7:0];
                    st_nxt.lo_valid = 1'b1;
                end
                `BMR_A_TEMP_TWO_RESULT_LOW, `BMR_A_TEMP_THREE_RESULT_LOW, `BMR_A_COULOMB_RESULT_LOW:
                begin
                    word = is_addr(addr_i, `BMR_A_COULOMB_RESULT_LOW) ? st_r.cc_lat
                        : snap_rd;
                    st_nxt.rdata = (st_r.lo_valid &&
                        !is_addr(addr_i, `BMR_A_TEMP_TWO_RESULT_LOW)) ? st_r.lo_hold
                        : word[7:0];
                    st_nxt.lo_valid = 1'b0;
                end
                `BMR_A_GAIN1: st_nxt.rdata = GAIN1_VAL;
                `BMR_A_OFFS: st_nxt.rdata = OFFS_VAL;
                `BMR_A_GAIN2: st_nxt.rdata = GAIN2_VAL;
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o = st_r.rdata;
    assign cell_balance_enable_o = st_r.bal;
    assign adc_enable_o = st_r.adc;
    assign ov_protect_enable_o = st_r.adc;
    assign temp_source_therm_o = st_r.tsel;
    assign shutdown_o = st_r.shutdown;
    assign protection_delay_bypass_o = st_r.ctl2[`BMR_B_DDIS];
    assign cc_active_o = st_r.cc_on;
    assign discharge_driver_pin_o = st_r.ctl2[`BMR_B_DSG];
    assign charge_driver_pin_o = st_r.ctl2[`BMR_B_CHG];
endmodule : bmr_regs

/* bmr_regs_asserts.sv */
`timescale 1ns/1ps
module bmr_regs_chk
#(
    parameter logic [7:0] GAIN1_VAL = 8'h00
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic [14:0] cell_balance_enable_o,
    input wire logic adc_enable_o,
    input wire logic ov_protect_enable_o,
    input wire logic temp_source_therm_o,
    input wire logic shutdown_o,
    input wire logic protection_delay_bypass_o,
    input wire logic cc_active_o,
    input wire logic discharge_driver_pin_o,
    input wire logic charge_driver_pin_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    logic w1;
    logic w4;
    logic w5;
    assign w1 = wr_i && addr_i == 8'h01;
    assign w4 = wr_i && addr_i == 8'h04;
    assign w5 = wr_i && addr_i == 8'h05;
    bal_write_a:
        assert property (w1 |=>
            cell_balance_enable_o[4:0] == $past(wdata_i[4:0]))
        else $error("balance enables not taken from write");
    bal_hold_a:
        assert property (!wr_i |=> $stable(cell_balance_enable_o))
        else $error("balance enables changed without write");
    bal_rsvd_a:
        assert property (rd_i && addr_i == 8'h02 |=> rdata_o[7:5] == 3'b000)
        else $error("balance upper bits not zero");
    drv_write_a:
        assert property (w5 |=> {discharge_driver_pin_o,
            charge_driver_pin_o} == $past(wdata_i[1:0]))
        else $error("driver outputs differ from write");
    bypass_write_a:
        assert property (w5 |=>
            protection_delay_bypass_o == $past(wdata_i[7]))
        else $error("delay bypass differs from write");
    adc_gate_a:
        assert property (w4 |=> adc_enable_o == $past(wdata_i[4])
            && ov_protect_enable_o == adc_enable_o)
        else $error("converter enable differs from write");
    tsel_write_a:
        assert property (w4 |=> temp_source_therm_o == $past(wdata_i[3]))
        else $error("temperature source differs from write");
    shut_seq_a:
        assert property ($rose(shutdown_o) |->
            $past(w4 && wdata_i[1:0] == 2'b10))
        else $error("shutdown without second step");
    cont_run_a:
        assert property (w5 && wdata_i[6] |=> ##1 cc_active_o [*3])
        else $error("continuous counting not running");
    cal_read_a:
        assert property (rd_i && addr_i == 8'h50 |=> rdata_o == GAIN1_VAL)
        else $error("gain constant read wrong");
endmodule : bmr_regs_chk

bind bmr_regs bmr_regs_chk #(.GAIN1_VAL(GAIN1_VAL)) i_chk
(
    .clk_i, .resetn_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o,
    .cell_balance_enable_o, .adc_enable_o, .ov_protect_enable_o,
    .temp_source_therm_o, .shutdown_o, .protection_delay_bypass_o,
    .cc_active_o, .discharge_driver_pin_o, .charge_driver_pin_o
);

/* bmr_host.sv */
`timescale 1ns/1ps
module bmr_host
(
    input wire logic clk_i,
    output logic wr_o,
    output logic rd_o,
    output logic txn_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    initial
    begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        txn_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    task automatic drive(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge clk_i);
        #1;
        // Address leads the strobe so the word store can read ahead
        addr_o = a;
        wdata_o = (a == 8'h04) ? (d & 8'hfb) : d;
        @(posedge clk_i);
        #1;
        wr_o = w;
        rd_o = !w;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        rd_o = 1'b0;
        // Released lines do not keep the last value
        addr_o = ~a;
        wdata_o = ~wdata_o;
    endtask : drive
    task automatic txn;
        @(posedge clk_i);
        #1;
        txn_o = 1'b1;
        @(posedge clk_i);
        #1;
        txn_o = 1'b0;
    endtask : txn
endmodule : bmr_host

/* bmr_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    miscompares++; $display("unexpected %s exp %h got %h", n, e, g); \
    end end
module tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ad = 1'b0;
    logic load = 1'b0;
    logic rd_q = 1'b0;
    logic [5:0] ev = 6'h00;
    logic [15:0] cc = 16'h0000;
    logic tsv = 1'b0;
    logic [13:0] t2 = 14'h0000;
    logic [13:0] t3 = 14'h0000;
    logic [15:0] a;
    logic wr, rd, txn, adc, ovp, tsel, shut, byp, cca, discharge_driver_pin, charge_driver_pin;
    logic [7:0] addr, wdata, rdata, exp_v, r [3];
    logic [7:0] q [$];
    logic [14:0] bal;
    int miscompares = 0;
    int comparisons = 0;
    int seed = 32'h89c3;
    bmr_host i_host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .txn_o(txn),
        .addr_o(addr), .wdata_o(wdata));
    bmr_regs #(.CC_CYCLES(8), .GAIN1_VAL(8'h5a), .OFFS_VAL(8'h3c),
        .GAIN2_VAL(8'hc3)) i_dut (.clk_i(clk), .resetn_i(resetn),
        .wr_i(wr), .rd_i(rd), .txn_start_i(txn), .addr_i(addr),
        .wdata_i(wdata), .rdata_o(rdata), .chip_fault_i(ev[5]),
        .alert_in_i(ev[4]), .alert_drive_i(ad), .uv_i(ev[3]),
        .ov_raw_i(ev[2]), .scd_i(ev[1]), .ocd_i(ev[0]),
        .load_seen_i(load), .cc_sample_i(cc), .ts_valid_i(tsv),
        .ts2_i(t2), .ts3_i(t3), .cell_balance_enable_o(bal),
        .adc_enable_o(adc), .ov_protect_enable_o(ovp),
        .temp_source_therm_o(tsel), .shutdown_o(shut),
        .protection_delay_bypass_o(byp), .cc_active_o(cca),
        .discharge_driver_pin_o(discharge_driver_pin), .charge_driver_pin_o(charge_driver_pin));
    initial
        forever #50 clk = ~clk;
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles
    task automatic wr_reg(input logic [7:0] ad_v, input logic [7:0] d);
        i_host.drive(1'b1, ad_v, d);
    endtask : wr_reg
    task automatic rd_exp(input logic [7:0] ad_v, input logic [7:0] e);
        q.push_back(e);
        i_host.drive(1'b0, ad_v, 8'h00);
    endtask : rd_exp
    task automatic pulse(input logic [5:0] v);
        ev = v;
        cycles(1);
        ev = 6'h00;
    endtask : pulse
    task automatic tpulse(input logic [13:0] v2, input logic [13:0] v3);
        t2 = v2;
        t3 = v3;
        tsv = 1'b1;
        cycles(1);
        tsv = 1'b0;
        cycles(1);
    endtask : tpulse
    task automatic end_of_test;
        if (miscompares == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // Read data stands one cycle after the strobe
    always @(posedge clk)
        rd_q <= rd;
    always @(negedge clk)
    begin
        if (rd_q)
        begin
            exp_v = q.pop_front();
            `CHK("rdata_o", exp_v, rdata)
        end
    end
    initial
    begin
        #2000000;
        miscompares++;
        end_of_test();
    end
    initial
    begin
        cycles(6);
        resetn = 1'b1;
        for (int i = 0; i < 6; i++)
            rd_exp(i[7:0], 8'h00);
        rd_exp(8'h50, 8'h5a);
        rd_exp(8'h51, 8'h3c);
        rd_exp(8'h59, 8'hc3);
        rd_exp(8'h7f, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            r[i] = 8'($random(seed));
            wr_reg(i[7:0] + 8'h01, r[i]);
            rd_exp(i[7:0] + 8'h01, r[i] & 8'h1f);
        end
        `CHK("bal", {r[2][4:0], r[1][4:0], r[0][4:0]}, bal)
        wr_reg(8'h04, 8'h10);
        pulse(6'h3f);
        rd_exp(8'h00, 8'h3f);
        wr_reg(8'h00, 8'h05);
        rd_exp(8'h00, 8'h3a);
        wr_reg(8'h00, 8'h00);
        rd_exp(8'h00, 8'h3a);
        wr_reg(8'h00, 8'hbf);
        ad = 1'b1;
        pulse(6'h10);
        ad = 1'b0;
        rd_exp(8'h00, 8'h00);
        wr_reg(8'h05, 8'h83);
        load = 1'b1;
        `CHK("drv", 3'b111, {byp, discharge_driver_pin, charge_driver_pin})
        rd_exp(8'h04, 8'h10);
        wr_reg(8'h05, 8'h02);
        rd_exp(8'h04, 8'h90);
        load = 1'b0;
        rd_exp(8'h04, 8'h10);
        wr_reg(8'h04, 8'h08);
        `CHK("ctl1", 3'b001, {adc, ovp, tsel})
        wr_reg(8'h04, 8'h10);
        `CHK("ctl1", 3'b110, {adc, ovp, tsel})
        // single trigger only with counter idle and continuous off
        cc = 16'($random(seed));
        wr_reg(8'h05, 8'h20);
        cycles(1);
        `CHK("cc_active", 1'b1, cca)
        cycles(7);
        `CHK("cc_active", 1'b1, cca)
        cycles(1);
        `CHK("cc_active", 1'b0, cca)
        rd_exp(8'h00, 8'h80);
        rd_exp(8'h05, 8'h00);
        rd_exp(8'h32, cc[15:8]);
        rd_exp(8'h33, cc[7:0]);
        wr_reg(8'h00, 8'h80);
        rd_exp(8'h00, 8'h00);
        a = cc;
        wr_reg(8'h05, 8'h40);
        cycles(30);
        rd_exp(8'h00, 8'h80);
        i_host.txn();
        rd_exp(8'h32, a[15:8]);
        cc = ~a;
        cycles(12);
        rd_exp(8'h33, a[7:0]);
        i_host.txn();
        rd_exp(8'h33, ~a[7:0]);
        wr_reg(8'h05, 8'h60);
        rd_exp(8'h05, 8'h40);
        `CHK("cc_active", 1'b1, cca)
        wr_reg(8'h05, 8'h00);
        cycles(12);
        wr_reg(8'h00, 8'h80);
        rd_exp(8'h00, 8'h00);
        // Temperature words alternate between the two store slots
        a = 16'($random(seed));
        tpulse(a[13:0], ~a[13:0]);
        tpulse(a[13:0], ~a[13:0]);
        rd_exp(8'h30, {2'b00, t3[13:8]});
        rd_exp(8'h31, t3[7:0]);
        rd_exp(8'h2f, t2[7:0]);
        rd_exp(8'h30, {2'b00, t3[13:8]});
        a[13:0] = t3;
        tpulse(t2, ~t3);
        rd_exp(8'h31, a[7:0]);
        rd_exp(8'h31, t3[7:0]);
        wr_reg(8'h04, 8'h11);
        wr_reg(8'h04, 8'h13);
        wr_reg(8'h04, 8'h12);
        `CHK("shutdown", 1'b0, shut)
        // two-step order from a cleared pair
        wr_reg(8'h04, 8'h10);
        wr_reg(8'h04, 8'h11);
        wr_reg(8'h04, 8'h12);
        `CHK("shutdown", 1'b1, shut)
        cycles(2);
        end_of_test();
    end
endmodule : tb
